/* hw/dpp_pkg.sv */
// Shared types and timing constants of the dual parallel port.
// Assumes one 200 MHz clock; strobe, data, ack and busy pins synchronised in the top module.
package dpp_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned CLK_MHZ    = 200;
  // Host ACK pulse width in ns, and in cycles rounded up
  localparam int unsigned ACK_NS     = 500;
  localparam int unsigned ACK_CYC    = (ACK_NS * CLK_MHZ + 999) / 1000;
  // Printer data setup and strobe width in ns
  localparam int unsigned SETUP_NS   = 500;
  localparam int unsigned SETUP_CYC  = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STB_NS     = 1000;
  localparam int unsigned STB_CYC    = (STB_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W      = 16;
  localparam logic [1:0]  SYNC_AGREE = 2'h3;

  // Channel pin groups
  typedef struct packed {
    logic              strobe_n;
    logic [DATA_W-1:0] data;
  } dpp_byte_t;

  // Where a load is performed
  typedef enum logic [1:0] {
    DPP_LOAD_NONE,
    DPP_LOAD_PARALLEL,
    DPP_LOAD_SERIAL
  } dpp_route_t;

endpackage

/* hw/dpp_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to mclk_i.
`timescale 1ns/100ps
module dpp_sync #(
  parameter int unsigned W   = 1,
  parameter logic [W-1:0] RV = '0
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  // Pins and clean levels
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s1_q <= RV;
      s2_q <= RV;
      s3_q <= RV;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change counts only once second and third stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        level_o[i] <= RV[i];
      end else if (s2_q[i] == s3_q[i]) begin
        level_o[i] <= s3_q[i];
      end
    end
  end

endmodule

/* hw/dpp_top.sv */
// Holds the host input channel, printer output channel and load routing.
// Assumes the loader drains load bytes via ld_ready_i; serial path is
// external and only selected here.
`timescale 1ns/100ps
module dpp_top #(
  parameter int unsigned ACK_CYCLES   = dpp_pkg::ACK_CYC,
  parameter int unsigned SETUP_CYCLES = dpp_pkg::SETUP_CYC,
  parameter int unsigned STB_CYCLES   = dpp_pkg::STB_CYC
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // Host input channel pins
  input  wire dpp_pkg::dpp_byte_t host_in_i,
  output logic                   host_ack_n_o,
  output logic                   host_busy_o,
  input  wire logic              host_pe_i,
  input  wire logic              host_err_i,
  // Printer output channel pins
  output dpp_pkg::dpp_byte_t     prn_out_o,
  input  wire logic              prn_ack_n_i,
  input  wire logic              prn_busy_i,
  input  wire logic              prn_pe_i,
  input  wire logic              prn_err_i,
  // Start-up mode and load control
  input  wire logic              hs_sel_i,
  input  wire logic              hs_sel_valid_i,
  input  wire logic              load_req_i,
  input  wire logic              load_done_i,
  input  wire logic              list_active_i,
  output dpp_pkg::dpp_route_t    load_route_o,
  output logic                   serial_fallback_o,
  // Load byte stream to the local loader
  output logic [dpp_pkg::DATA_W-1:0] ld_data_o,
  output logic                   ld_valid_o,
  input  wire logic              ld_ready_i
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int unsigned SW = dpp_pkg::DATA_W + 3;

  logic [SW-1:0] raw_w;
  logic [SW-1:0] clean_w;
  logic          h_stb_n;
  logic [dpp_pkg::DATA_W-1:0] h_data;
  logic          p_ack_n;
  logic          p_busy;
  logic          h_stb_n_q;
  logic          stb_fall;

  assign raw_w = {host_in_i.strobe_n, host_in_i.data,
                  prn_ack_n_i, prn_busy_i};

  // Idle strobe and ack high, busy assumed high until seen low
  dpp_sync #(
    .W  (SW),
    .RV ({1'h1, {dpp_pkg::DATA_W{1'h0}}, 1'h1, 1'h1})
  ) u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .pin_i   (raw_w),
    .level_o (clean_w)
  );

  assign {h_stb_n, h_data, p_ack_n, p_busy} = clean_w;

  // Paper-end and error are pulled up and carry no function
  logic unused_status;
  assign unused_status = host_pe_i ^ host_err_i ^ prn_pe_i ^ prn_err_i;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      h_stb_n_q <= 1'h1;
    end else begin
      h_stb_n_q <= h_stb_n;
    end
  end

  assign stb_fall = h_stb_n_q & ~h_stb_n;

  ////////////////////////////////////////////////////////////////////
  // Mode and load routing

  logic hs_mode_q;
  logic hs_done_q;
  logic loading_q;
  logic fwd_busy;

  // Mode is caught once after reset, never changed later
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hs_mode_q <= 1'h0;
      hs_done_q <= 1'h0;
    end else if (hs_sel_valid_i && !hs_done_q) begin
      hs_mode_q <= hs_sel_i;
      hs_done_q <= 1'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      loading_q         <= 1'h0;
      load_route_o      <= dpp_pkg::DPP_LOAD_NONE;
      serial_fallback_o <= 1'h0;
    end else if (load_req_i && load_route_o == dpp_pkg::DPP_LOAD_NONE) begin
      if (!hs_mode_q) begin
        load_route_o <= dpp_pkg::DPP_LOAD_SERIAL;
      end else if (list_active_i || fwd_busy) begin
        load_route_o      <= dpp_pkg::DPP_LOAD_SERIAL;
        serial_fallback_o <= 1'h1;
      end else begin
        load_route_o <= dpp_pkg::DPP_LOAD_PARALLEL;
        loading_q    <= 1'h1;
      end
    end else if (load_done_i) begin
      loading_q         <= 1'h0;
      load_route_o      <= dpp_pkg::DPP_LOAD_NONE;
      serial_fallback_o <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Host input channel

  typedef enum logic [2:0] {
    H_IDLE,
    H_HOLD,
    H_ACK,
    H_WAIT_HI
  } dpp_hst_t;

  dpp_hst_t                   h_st_q;
  logic [dpp_pkg::DATA_W-1:0] h_byte_q;
  logic                       h_to_load_q;
  logic [dpp_pkg::CNT_W-1:0]  h_cnt_q;
  logic                       byte_taken;
  logic                       fwd_take;

  // Consumed by loader or printer side, depending on destination
  assign byte_taken = h_to_load_q ? (ld_valid_o && ld_ready_i) : fwd_take;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      h_st_q       <= H_IDLE;
      host_busy_o  <= 1'h0;
      host_ack_n_o <= 1'h1;
      h_byte_q     <= '0;
      h_to_load_q  <= 1'h0;
      h_cnt_q      <= '0;
      ld_valid_o   <= 1'h0;
      ld_data_o    <= '0;
    end else begin
      unique case (h_st_q)
        H_IDLE: begin
          if (stb_fall) begin
            host_busy_o <= 1'h1;
            h_byte_q    <= h_data;
            h_to_load_q <= loading_q;
            ld_valid_o  <= loading_q;
            ld_data_o   <= h_data;
            h_st_q      <= H_HOLD;
          end
        end
        H_HOLD: begin
          // Busy held until byte is consumed; this stalls the host
          if (byte_taken) begin
            ld_valid_o   <= 1'h0;
            host_ack_n_o <= 1'h0;
            h_cnt_q      <= dpp_pkg::CNT_W'(ACK_CYCLES);
            h_st_q       <= H_ACK;
          end
        end
        H_ACK: begin
          if (h_cnt_q <= dpp_pkg::CNT_W'(1)) begin
            host_ack_n_o <= 1'h1;
            h_st_q       <= H_WAIT_HI;
          end else begin
            h_cnt_q <= h_cnt_q - dpp_pkg::CNT_W'(1);
          end
        end
        H_WAIT_HI: begin
          // Keep busy until strobe returns high, avoids a double take
          if (h_stb_n) begin
            host_busy_o <= 1'h0;
            h_st_q      <= H_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Printer output channel

  typedef enum logic [2:0] {
    P_IDLE,
    P_SETUP,
    P_STROBE,
    P_WAIT_ACK
  } dpp_pst_t;

  dpp_pst_t                  p_st_q;
  logic [dpp_pkg::CNT_W-1:0] p_cnt_q;

  // Forward only when idle; busy printer defers the handoff
  assign fwd_take = !h_to_load_q && h_st_q == H_HOLD &&
                    p_st_q == P_IDLE && !p_busy;
  assign fwd_busy = p_st_q != P_IDLE ||
                    (h_st_q != H_IDLE && !h_to_load_q);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      p_st_q             <= P_IDLE;
      p_cnt_q            <= '0;
      prn_out_o.strobe_n <= 1'h1;
      prn_out_o.data     <= '0;
    end else begin
      unique case (p_st_q)
        P_IDLE: begin
          if (fwd_take) begin
            prn_out_o.data <= h_byte_q;
            p_cnt_q        <= dpp_pkg::CNT_W'(SETUP_CYCLES);
            p_st_q         <= P_SETUP;
          end
        end
        P_SETUP: begin
          if (p_cnt_q <= dpp_pkg::CNT_W'(1)) begin
            prn_out_o.strobe_n <= 1'h0;
            p_cnt_q            <= dpp_pkg::CNT_W'(STB_CYCLES);
            p_st_q             <= P_STROBE;
          end else begin
            p_cnt_q <= p_cnt_q - dpp_pkg::CNT_W'(1);
          end
        end
        P_STROBE: begin
          if (p_cnt_q <= dpp_pkg::CNT_W'(1)) begin
            prn_out_o.strobe_n <= 1'h1;
            p_st_q             <= P_WAIT_ACK;
          end else begin
            p_cnt_q <= p_cnt_q - dpp_pkg::CNT_W'(1);
          end
        end
        P_WAIT_ACK: begin
          // Printer done when it acks or is no longer busy
          if (!p_ack_n || !p_busy) begin
            p_st_q <= P_IDLE;
          end
        end
      endcase
    end
  end

endmodule

/* testbench/dpp_monitor.sv */
// Checker on the dual parallel port top ports.
// Assumes ACK, setup and strobe counts shortened to 2 cycles.
`timescale 1ns/100ps
module dpp_monitor #(
  parameter int unsigned ACK_CYCLES = 2,
  parameter int unsigned STB_CYCLES = 2
) (
  input wire logic                      mclk_i,
  input wire logic                      reset_i,
  input wire logic                      host_ack_n_o,
  input wire logic                      host_busy_o,
  input wire dpp_pkg::dpp_byte_t        prn_out_o,
  input wire logic                      prn_busy_i,
  input wire logic                      load_req_i,
  input wire logic                      load_done_i,
  input wire logic                      list_active_i,
  input wire dpp_pkg::dpp_route_t       load_route_o,
  input wire logic                      serial_fallback_o,
  input wire logic [dpp_pkg::DATA_W-1:0] ld_data_o,
  input wire logic                      ld_valid_o,
  input wire logic                      ld_ready_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Low for two cycles, then back high
  sequence low2_s(sig);
    !sig [*2] ##1 sig;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_ACK_WIDTH: assert property ($fell(host_ack_n_o) |-> low2_s(host_ack_n_o))
    else $error("host ack pulse width wrong");
  AST_ACK_BUSY: assert property (!host_ack_n_o |-> host_busy_o)
    else $error("host ack outside busy");
  AST_STB_WIDTH: assert property ($fell(prn_out_o.strobe_n)
    |-> low2_s(prn_out_o.strobe_n)) else $error("printer strobe width wrong");
  AST_DATA_HOLD: assert property (!prn_out_o.strobe_n
    |-> $stable(prn_out_o.data)) else $error("printer data moved in strobe");
  // Margin covers the pin synchroniser delay
  AST_BUSY_WAIT: assert property (prn_busy_i [*8]
    |=> !$fell(prn_out_o.strobe_n)) else $error("strobe while printer busy");
  AST_FALLBACK: assert property (serial_fallback_o
    |-> load_route_o == dpp_pkg::DPP_LOAD_SERIAL) else $error("fallback route");
  AST_LIST_SERIAL: assert property (load_req_i && list_active_i &&
    load_route_o == dpp_pkg::DPP_LOAD_NONE |=> load_route_o ==
    dpp_pkg::DPP_LOAD_SERIAL) else $error("load not diverted to serial");
  AST_DONE: assert property (load_done_i && !load_req_i
    |=> load_route_o == dpp_pkg::DPP_LOAD_NONE) else $error("route not freed");
  AST_LD_HOLD: assert property (ld_valid_o && !ld_ready_i
    |=> ld_valid_o && $stable(ld_data_o)) else $error("load byte dropped");
endmodule

/* testbench/dpp_printer_model.sv */
// Printer on the printer output channel.
// Assumes the device holds data steady while strobe is low.
`timescale 1ns/100ps
module dpp_printer_model (
  input  wire logic                      mclk_i,
  input  wire dpp_pkg::dpp_byte_t        prn_i,
  input  wire logic                      slow_i,
  output logic                           busy_o,
  output logic                           ack_n_o,
  output logic                           pe_o,
  output logic                           err_o,
  output logic                           got_o,
  output logic [dpp_pkg::DATA_W-1:0]     got_data_o
);
  // Pull-ups only: status lines carry nothing
  assign pe_o  = 1'b1;
  assign err_o = 1'b1;
  initial begin
    busy_o     = 1'b0;
    ack_n_o    = 1'b1;
    got_o      = 1'b0;
    got_data_o = '0;
    forever begin
      @(negedge prn_i.strobe_n);
      @(posedge mclk_i);
      busy_o     <= 1'b1;
      got_o      <= 1'b1;
      got_data_o <= prn_i.data;
      @(posedge mclk_i);
      got_o <= 1'b0;
      repeat (slow_i ? 60 : 3) @(posedge mclk_i);
      ack_n_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
      ack_n_o <= 1'b1;
      busy_o  <= 1'b0;
    end
  end
endmodule

/* testbench/dpp_tb_top.sv */
// Self-checking bench of the dual parallel port.
// Assumes the printer model on the output channel.
`timescale 1ns/100ps
module dpp_tb_top;
  logic mclk_i, reset_i, hs_sel_i, hs_sel_valid_i, load_req_i, load_done_i;
  logic list_active_i, ld_ready_i, slow_i, host_ack_n_o, host_busy_o;
  logic prn_ack_n_i, prn_busy_i, prn_pe_i, prn_err_i, serial_fallback_o;
  logic ld_valid_o, got_o;
  logic [7:0]          ld_data_o, got_data;
  dpp_pkg::dpp_byte_t  host_in_i, prn_out_o;
  dpp_pkg::dpp_route_t load_route_o;
  logic [7:0]          prn_q[$], ld_q[$];
  int                  error_cnt = 0, num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  dpp_top #(.ACK_CYCLES(2), .SETUP_CYCLES(2), .STB_CYCLES(2)) dpp_top_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .host_in_i(host_in_i),
    .host_ack_n_o(host_ack_n_o), .host_busy_o(host_busy_o),
    .host_pe_i(1'b1), .host_err_i(1'b1), .prn_out_o(prn_out_o),
    .prn_ack_n_i(prn_ack_n_i), .prn_busy_i(prn_busy_i), .prn_pe_i(prn_pe_i),
    .prn_err_i(prn_err_i), .hs_sel_i(hs_sel_i),
    .hs_sel_valid_i(hs_sel_valid_i), .load_req_i(load_req_i),
    .load_done_i(load_done_i), .list_active_i(list_active_i),
    .load_route_o(load_route_o), .serial_fallback_o(serial_fallback_o),
    .ld_data_o(ld_data_o), .ld_valid_o(ld_valid_o), .ld_ready_i(ld_ready_i));
  dpp_printer_model dpp_printer_model_i (.mclk_i(mclk_i), .prn_i(prn_out_o),
    .slow_i(slow_i), .busy_o(prn_busy_i), .ack_n_o(prn_ack_n_i),
    .pe_o(prn_pe_i), .err_o(prn_err_i), .got_o(got_o), .got_data_o(got_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Expected byte noted by destination at strobe time
  task automatic send_byte(input logic [7:0] d);
    int n;
    logic acked;
    acked = 1'b0;
    host_in_i = {1'b0, d};
    if (load_route_o === dpp_pkg::DPP_LOAD_PARALLEL) ld_q.push_back(d);
    else prn_q.push_back(d);
    for (n = 0; n < 3000 && host_busy_o !== 1'b1; n++) @(negedge mclk_i);
    host_in_i = {1'b1, ~d};
    for (n = 0; n < 3000 && host_busy_o !== 1'b0; n++) begin
      if (host_ack_n_o === 1'b0) acked = 1'b1;
      @(negedge mclk_i);
    end
    chk(9'h001, {8'h00, acked});
  endtask
  task automatic drain;
    int n;
    for (n = 0; n < 5000 && (prn_q.size() || ld_q.size() || prn_busy_i); n++)
      @(negedge mclk_i);
    repeat (8) @(negedge mclk_i);
  endtask
  task automatic boot(input logic hs);
    reset_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    reset_i        = 1'b0;
    hs_sel_i       = hs;
    hs_sel_valid_i = 1'b1;
    @(negedge mclk_i);
    hs_sel_valid_i = 1'b0;
    hs_sel_i       = ~hs;
  endtask
  task automatic load_cmd(input logic lst, input dpp_pkg::dpp_route_t r);
    list_active_i = lst;
    load_req_i    = 1'b1;
    @(negedge mclk_i);
    load_req_i = 1'b0;
    @(negedge mclk_i);
    chk({7'h0, r}, {7'h0, load_route_o});
    chk({8'h0, lst}, {8'h0, serial_fallback_o});
  endtask
  task automatic load_end;
    repeat (3) send_byte(8'($urandom));
    drain();
    load_done_i = 1'b1;
    @(negedge mclk_i);
    load_done_i = 1'b0;
    @(negedge mclk_i);
    chk({7'h0, dpp_pkg::DPP_LOAD_NONE}, {7'h0, load_route_o});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  always @(negedge mclk_i) ld_ready_i <= 1'($urandom_range(1, 0));
  always @(posedge mclk_i) begin
    if (got_o === 1'b1)
      chk(prn_q.size() ? {1'b0, prn_q.pop_front()} : 9'h100, {1'b0, got_data});
    if (ld_valid_o === 1'b1 && ld_ready_i === 1'b1)
      chk(ld_q.size() ? {1'b0, ld_q.pop_front()} : 9'h100, {1'b0, ld_data_o});
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hB301B5BD));
    {reset_i, hs_sel_i, hs_sel_valid_i, load_req_i, load_done_i} = 5'h10;
    {list_active_i, slow_i} = 2'h0;
    host_in_i = {1'b1, 8'h00};
    boot(1'b1);
    repeat (6) begin
      slow_i = 1'($urandom_range(1, 0));
      send_byte(8'($urandom));
    end
    drain();
    $display("test pass-through done");
    load_cmd(1'b0, dpp_pkg::DPP_LOAD_PARALLEL);
    load_end();
    $display("test parallel load done");
    load_cmd(1'b1, dpp_pkg::DPP_LOAD_SERIAL);
    load_end();
    $display("test serial fallback done");
    boot(1'b0);
    load_cmd(1'b0, dpp_pkg::DPP_LOAD_SERIAL);
    load_end();
    $display("test normal load done");
    finish_test();
  end
endmodule
bind dpp_top dpp_monitor #(.ACK_CYCLES(ACK_CYCLES), .STB_CYCLES(STB_CYCLES))
  dpp_monitor_i (.mclk_i(mclk_i), .reset_i(reset_i),
  .host_ack_n_o(host_ack_n_o), .host_busy_o(host_busy_o),
  .prn_out_o(prn_out_o), .prn_busy_i(prn_busy_i), .load_req_i(load_req_i),
  .load_done_i(load_done_i), .list_active_i(list_active_i),
  .load_route_o(load_route_o), .serial_fallback_o(serial_fallback_o),
  .ld_data_o(ld_data_o), .ld_valid_o(ld_valid_o), .ld_ready_i(ld_ready_i));
